// file: acc_pkg.sv
// constants, types and helpers shared by the converter control block
// Functional notes
// - control bit 31 selects how each result is written into the result field
// - start bit one runs conversion; zero stops it and the converter idles
// - start bit is set by software, PWM centre trigger or external trigger pin
// - single and single-cycle scan modes: hardware clears start when finished
// - continuous scan keeps converting; software clears start to end it
// - differential select: zero single-ended inputs, one differential inputs
// - differential pairs 0/1, 2/3, 4/5, 6/7; even positive; pair index 0 to 3
// - differential: only even channel enabled; result goes to that even channel
// - with dma enable, every result loaded raises a dma transfer request
// - hardware trigger enable gates pin and PWM starts; zero blocks them
// - hardware triggering works only in single-cycle scan mode
// - qualifying event from selected trigger source sets the start bit
// - format zero: unsigned, top four bits zero; one: sign-extended
// - operation mode 00 single, 10 single-cycle scan, 11 continuous, 01 reserved
// - trigger condition 00 low, 01 high, 10 falling edge, 11 rising edge
// - trigger source 00 external pin, 11 PWM centre trigger, others reserved
package acc_pkg;

   localparam logic [7:0] ADDR_CTRL = 8'h20;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h8000_0fff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int EXT_LEVEL_CYC = 8;
   localparam int EXT_EDGE_CYC = 4;
   localparam int RAW_W = 12;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_RSVD = 2'b01,
      MODE_CYCLE_SCAN = 2'b10,
      MODE_CONT_SCAN = 2'b11
   } acc_mode_t;

   typedef enum logic [1:0] {
      COND_LOW = 2'b00,
      COND_HIGH = 2'b01,
      COND_FALL = 2'b10,
      COND_RISE = 2'b11
   } acc_cond_t;

   typedef enum logic [1:0] {
      SRC_PIN = 2'b00,
      SRC_RSVD1 = 2'b01,
      SRC_RSVD2 = 2'b10,
      SRC_PWM = 2'b11
   } acc_src_t;

   // bit layout of converter_control_reg, msb first
   typedef struct packed {
      logic result_signed_format;
      logic [18:0] rsvd;
      logic conversion_start;
      logic differential_select;
      logic dma_request_enable;
      logic hw_trigger_enable;
      acc_cond_t ext_trigger_condition;
      acc_src_t hw_trigger_source;
      acc_mode_t operation_select;
      logic done_irq_enable;
      logic converter_enable;
   } acc_ctrl_t;

   typedef struct packed {
      logic [2:0] channel;
      logic [1:0] pair;
      logic diff;
      logic [15:0] data;
   } acc_result_t;

   typedef enum logic {
      WR_COLLECT = 1'b0,
      WR_RESP = 1'b1
   } acc_wr_t;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } acc_rd_t;

   function automatic logic [15:0] acc_format(input logic [RAW_W-1:0] raw, input logic sfmt);
      acc_format = sfmt ? {{4{raw[RAW_W-1]}}, raw} : {4'h0, raw};
   endfunction : acc_format

endpackage : acc_pkg

// file: acc_trig_qual.sv
// external trigger pin qualifier: level and edge detection with stability filter
`timescale 1ns/10ps
module acc_trig_qual import acc_pkg::*; #(
   parameter int LEVEL_CYC = EXT_LEVEL_CYC,
   parameter int EDGE_CYC = EXT_EDGE_CYC
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // pin and condition
   input wire logic pin_i,
   input acc_cond_t cond_i,
   // qualified event
   output logic event_o
);

   logic samp;
   logic [3:0] cnt;
   logic filt;
   logic next_samp;
   logic [3:0] next_cnt;
   logic next_filt;
   logic next_event;

   always_comb begin
      next_samp = pin_i;
      next_cnt = 4'h0;
      if (pin_i == samp) begin
         next_cnt = (cnt == 4'hf) ? cnt : cnt + 4'h1;
      end
      // filtered level only moves after the pin has held still, so glitches give no edge
      next_filt = filt;
      if (cnt >= 4'(EDGE_CYC - 1)) begin
         next_filt = samp;
      end
      case (cond_i)
         COND_LOW: next_event = !samp && (cnt >= 4'(LEVEL_CYC - 1));
         COND_HIGH: next_event = samp && (cnt >= 4'(LEVEL_CYC - 1));
         COND_FALL: next_event = filt && !next_filt;
         COND_RISE: next_event = !filt && next_filt;
         default: next_event = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         samp <= 1'b0;
         cnt <= 4'h0;
         filt <= 1'b0;
         event_o <= 1'b0;
      end else begin
         samp <= next_samp;
         cnt <= next_cnt;
         filt <= next_filt;
         event_o <= next_event;
      end
   end

   a_rise_needs_low : assert property (@(posedge core_clk_i) disable iff (rst_i)
      ($past(cond_i) == COND_RISE) && event_o |-> $rose(filt) && $past(samp))
      else $error("rising event without a high pin sample");

endmodule : acc_trig_qual

// file: acc_conversion_control.sv
// converter control register with AXI4-Lite access, trigger and result formatting
`timescale 1ns/10ps
module acc_conversion_control import acc_pkg::*; #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // axi4-lite write address and data
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // converter core
   input wire logic conv_done_i,
   input wire logic [2:0] conv_channel_i,
   input wire logic [RAW_W-1:0] conv_data_i,
   input wire logic cycle_done_i,
   // hardware triggers
   input wire logic ext_trigger_pin_i,
   input wire logic pwm_trigger_i,
   // control and results
   output acc_ctrl_t ctrl_o,
   output acc_result_t result_o,
   output logic result_valid_o,
   output logic dma_req_o
);

   function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
      is_ctrl = (a[ADDR_W-1:2] == (ADDR_W-2)'(ADDR_CTRL[7:2]));
   endfunction : is_ctrl

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      merge = m & CTRL_WMASK;
   endfunction : merge

   // write channel state
   acc_wr_t wr_state;
   acc_wr_t next_wr_state;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic [ADDR_W-1:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic aw_fire;
   logic w_fire;
   logic wr_go;
   logic sw_wr_ctrl;

   always_comb begin
      aw_fire = s_axi_awvalid_i && s_axi_awready_o;
      w_fire = s_axi_wvalid_i && s_axi_wready_o;
      next_aw_held = aw_held || aw_fire;
      next_w_held = w_held || w_fire;
      next_aw_addr = aw_fire ? s_axi_awaddr_i : aw_addr;
      next_w_data = w_fire ? s_axi_wdata_i : w_data;
      next_w_strb = w_fire ? s_axi_wstrb_i : w_strb;
      next_wr_state = wr_state;
      next_bvalid = s_axi_bvalid_o;
      next_bresp = s_axi_bresp_o;
      wr_go = 1'b0;
      case (wr_state)
         WR_COLLECT: begin
            if (next_aw_held && next_w_held) begin
               wr_go = 1'b1;
               next_wr_state = WR_RESP;
               next_bvalid = 1'b1;
               next_bresp = is_ctrl(next_aw_addr) ? RESP_OKAY : RESP_SLVERR;
               next_aw_held = 1'b0;
               next_w_held = 1'b0;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_i) begin
               next_wr_state = WR_COLLECT;
               next_bvalid = 1'b0;
            end
         end
         default: next_wr_state = WR_COLLECT;
      endcase
      // channels reopen only when the response is gone, one write at a time
      next_awready = (next_wr_state == WR_COLLECT) && !next_aw_held;
      next_wready = (next_wr_state == WR_COLLECT) && !next_w_held;
      sw_wr_ctrl = wr_go && is_ctrl(next_aw_addr);
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_state <= WR_COLLECT;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready_o <= next_awready;
         s_axi_wready_o <= next_wready;
         s_axi_bvalid_o <= next_bvalid;
         s_axi_bresp_o <= next_bresp;
      end
   end

   // read channel
   acc_rd_t rd_state;
   acc_rd_t next_rd_state;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   always_comb begin
      next_rd_state = rd_state;
      next_arready = s_axi_arready_o;
      next_rvalid = s_axi_rvalid_o;
      next_rdata = s_axi_rdata_o;
      next_rresp = s_axi_rresp_o;
      case (rd_state)
         RD_IDLE: begin
            next_arready = 1'b1;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
               next_rd_state = RD_RESP;
               next_arready = 1'b0;
               next_rvalid = 1'b1;
               next_rdata = is_ctrl(s_axi_araddr_i) ? ctrl_o : 32'h0;
               next_rresp = is_ctrl(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            end
         end
         RD_RESP: begin
            if (s_axi_rready_i) begin
               next_rd_state = RD_IDLE;
               next_rvalid = 1'b0;
               next_arready = 1'b1;
            end
         end
         default: next_rd_state = RD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_state <= RD_IDLE;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= RESP_OKAY;
      end else begin
         rd_state <= next_rd_state;
         s_axi_arready_o <= next_arready;
         s_axi_rvalid_o <= next_rvalid;
         s_axi_rdata_o <= next_rdata;
         s_axi_rresp_o <= next_rresp;
      end
   end

   // hardware trigger selection
   logic pin_event;
   logic src_event;
   logic hw_trig;

   acc_trig_qual #(
      .LEVEL_CYC(EXT_LEVEL_CYC),
      .EDGE_CYC(EXT_EDGE_CYC)
   ) u_qual (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(ext_trigger_pin_i),
      .cond_i(ctrl_o.ext_trigger_condition),
      .event_o(pin_event)
   );

   always_comb begin
      case (ctrl_o.hw_trigger_source)
         SRC_PIN: src_event = pin_event;
         SRC_PWM: src_event = pwm_trigger_i;
         default: src_event = 1'b0;
      endcase
      hw_trig = ctrl_o.hw_trigger_enable && (ctrl_o.operation_select == MODE_CYCLE_SCAN)
                && src_event;
   end

   // control register and result path
   acc_ctrl_t next_ctrl;
   acc_result_t next_result;
   logic next_result_valid;
   logic next_dma_req;
   logic auto_stop;

   always_comb begin
      next_ctrl = ctrl_o;
      // single conversion and single-cycle scan stop themselves
      auto_stop = cycle_done_i && ((ctrl_o.operation_select == MODE_SINGLE) ||
                                   (ctrl_o.operation_select == MODE_CYCLE_SCAN));
      if (auto_stop) begin
         next_ctrl.conversion_start = 1'b0;
      end
      // a software write of one overrides the automatic clear in the same cycle
      if (sw_wr_ctrl) begin
         next_ctrl = acc_ctrl_t'(merge(ctrl_o, next_w_data, next_w_strb));
      end
      // hardware set wins over any clear in the same cycle
      if (hw_trig) begin
         next_ctrl.conversion_start = 1'b1;
      end
      next_ctrl.rsvd = '0;
      next_result = result_o;
      next_result_valid = 1'b0;
      next_dma_req = 1'b0;
      if (conv_done_i) begin
         // differential pair result lands on the enabled even channel
         next_result.diff = ctrl_o.differential_select;
         next_result.pair = conv_channel_i[2:1];
         next_result.channel = ctrl_o.differential_select ?
                               {conv_channel_i[2:1], 1'b0} : conv_channel_i;
         next_result.data = acc_format(conv_data_i, ctrl_o.result_signed_format);
         next_result_valid = 1'b1;
         next_dma_req = ctrl_o.dma_request_enable;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_o <= acc_ctrl_t'(CTRL_RESET);
         result_o <= '0;
         result_valid_o <= 1'b0;
         dma_req_o <= 1'b0;
      end else begin
         ctrl_o <= next_ctrl;
         result_o <= next_result;
         result_valid_o <= next_result_valid;
         dma_req_o <= next_dma_req;
      end
   end

   // checks
   sequence s_done_unsigned;
      conv_done_i && !ctrl_o.result_signed_format;
   endsequence

   sequence s_done_signed;
      conv_done_i && ctrl_o.result_signed_format;
   endsequence

   sequence s_write_both;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence

   a_fmt_unsigned : assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_done_unsigned |=> result_valid_o && (result_o.data[15:12] == 4'h0)
                          && (result_o.data[11:0] == $past(conv_data_i)))
      else $error("unsigned result not zero-extended");

   a_fmt_signed : assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_done_signed |=> result_o.data == {{4{$past(conv_data_i[11])}}, $past(conv_data_i)})
      else $error("signed result not sign-extended");

   a_diff_even : assert property (@(posedge core_clk_i) disable iff (rst_i)
      conv_done_i && ctrl_o.differential_select |=> !result_o.channel[0]
         && (result_o.pair == $past(conv_channel_i[2:1])))
      else $error("differential result not on even channel");

   a_dma_request : assert property (@(posedge core_clk_i) disable iff (rst_i)
      dma_req_o |-> $past(conv_done_i) && $past(ctrl_o.dma_request_enable) && result_valid_o)
      else $error("dma request without a loaded result");

   a_hw_start : assert property (@(posedge core_clk_i) disable iff (rst_i)
      hw_trig |=> ctrl_o.conversion_start)
      else $error("hardware trigger did not set start");

   a_hw_blocked : assert property (@(posedge core_clk_i) disable iff (rst_i)
      !ctrl_o.conversion_start && !sw_wr_ctrl && (!ctrl_o.hw_trigger_enable ||
         ctrl_o.operation_select != MODE_CYCLE_SCAN) |=> !ctrl_o.conversion_start)
      else $error("start set while hardware starts are blocked");

   a_auto_clear : assert property (@(posedge core_clk_i) disable iff (rst_i)
      auto_stop && !sw_wr_ctrl && !hw_trig |=> !ctrl_o.conversion_start)
      else $error("start not cleared at end of single or scan cycle");

   a_cont_hold : assert property (@(posedge core_clk_i) disable iff (rst_i)
      cycle_done_i && ctrl_o.conversion_start && !sw_wr_ctrl
         && ctrl_o.operation_select == MODE_CONT_SCAN |=> ctrl_o.conversion_start)
      else $error("continuous scan stopped without software");

   a_write_resp : assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_write_both ##1 1'b1 |-> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
      else $error("write response not raised one cycle after address and data");

   a_read_ctrl : assert property (@(posedge core_clk_i) disable iff (rst_i)
      s_axi_arvalid_i && s_axi_arready_o && is_ctrl(s_axi_araddr_i)
         |=> s_axi_rvalid_o && (s_axi_rdata_o == $past(ctrl_o)))
      else $error("control read returned stale value");

endmodule : acc_conversion_control

// file: acc_core_model.sv
// converter core stand-in: paces conversions while the start bit is set
`timescale 1ns/10ps
module acc_core_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // control from the block and the bench
   input wire logic start_i,
   input wire logic [7:0] delay_i,
   input wire logic [2:0] chan_i,
   input wire logic [11:0] data_i,
   // towards the block
   output logic conv_done_o,
   output logic [2:0] conv_channel_o,
   output logic [11:0] conv_data_o,
   output logic cycle_done_o
);
   logic [7:0] cnt;

   // one result every delay_i plus one cycles; idle result lines toggle so stale data never looks valid
   always_ff @(posedge core_clk_i) begin
      conv_done_o <= 1'b0;
      cycle_done_o <= conv_done_o && !rst_i;
      conv_channel_o <= ~conv_channel_o;
      conv_data_o <= ~conv_data_o;
      if (rst_i) begin
         cnt <= 8'h00;
         conv_channel_o <= 3'h0;
         conv_data_o <= 12'h000;
      end else if (!start_i) begin
         cnt <= 8'h00;
      end else if (cnt == delay_i) begin
         cnt <= 8'h00;
         conv_done_o <= 1'b1;
         conv_channel_o <= chan_i;
         conv_data_o <= data_i;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : acc_core_model

// file: acc_conversion_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module acc_conversion_control_tb import acc_pkg::*; ;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, conv_done, cycle_done, pin, pwm, result_valid, dma_req, dma_seen;
   logic [7:0] awaddr, araddr, delay;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [2:0] conv_ch, chan;
   logic [11:0] conv_data, data;
   logic seen;
   acc_ctrl_t ctrl;
   acc_result_t res, res_seen;
   int n_res, n0, checked, bad_count;
   logic [31:0] ctl_tab [5] = '{32'h0000_0801, 32'h8000_0a09, 32'h8000_0a01, 32'h8000_0e09,
                                32'h0000_0c09};
   logic [2:0] ch_tab [5] = '{3'd5, 3'd6, 3'd1, 3'd2, 3'd6};
   logic [11:0] d_tab [5] = '{12'h800, 12'h800, 12'h7ff, 12'h800, 12'hfff};
   // pair index follows channel bits 2:1 in both input modes
   logic [21:0] exp_tab [5] = '{{3'd5, 2'd2, 1'b0, 16'h0800}, {3'd6, 2'd3, 1'b0, 16'hf800},
      {3'd1, 2'd0, 1'b0, 16'h07ff}, {3'd2, 2'd1, 1'b1, 16'hf800}, {3'd6, 2'd3, 1'b1, 16'h0fff}};
   logic [31:0] hw_tab [6] = '{32'h139, 32'h039, 32'h131, 32'h13d, 32'h119, 32'h129};

   acc_conversion_control i_dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .conv_done_i(conv_done), .conv_channel_i(conv_ch),
      .conv_data_i(conv_data), .cycle_done_i(cycle_done), .ext_trigger_pin_i(pin),
      .pwm_trigger_i(pwm), .ctrl_o(ctrl), .result_o(res), .result_valid_o(result_valid),
      .dma_req_o(dma_req));

   acc_core_model i_core (.core_clk_i(clk), .rst_i(rst), .start_i(ctrl.conversion_start),
      .delay_i(delay), .chan_i(chan), .data_i(data), .conv_done_o(conv_done),
      .conv_channel_o(conv_ch), .conv_data_o(conv_data), .cycle_done_o(cycle_done));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // results are pulses, so catch them mid-cycle where they are settled
   always @(negedge clk) begin
      if (result_valid === 1'b1) begin
         res_seen = res;
         dma_seen = dma_req;
         n_res++;
      end
   end

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask : check

   task automatic timed_out();
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      stop_test();
   endtask : timed_out

   // readies are registered, so a mid-cycle look tells what the next edge takes
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
      for (int n = 0; n < 50 && !b_t; n++) begin
         @(negedge clk);
         aw_t = awvalid && awready === 1'b1;
         w_t = wvalid && wready === 1'b1;
         b_t = bvalid === 1'b1;
         if (b_t) check({30'h0, bresp}, {30'h0, er});
         @(posedge clk);
         if (aw_t) begin awvalid <= 1'b0; awaddr <= ~a; end
         if (w_t) begin wvalid <= 1'b0; wdata <= ~d; end
         if (b_t) bready <= 1'b0;
      end
      if (!b_t) timed_out();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic a_t, r_t;
      r_t = 1'b0;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (int n = 0; n < 50 && !r_t; n++) begin
         @(negedge clk);
         a_t = arvalid && arready === 1'b1;
         r_t = rvalid === 1'b1;
         if (r_t) check(rdata, exp);
         if (r_t) check({30'h0, rresp}, {30'h0, er});
         @(posedge clk);
         if (a_t) begin arvalid <= 1'b0; araddr <= ~a; end
         if (r_t) rready <= 1'b0;
      end
      if (!r_t) timed_out();
   endtask : rd

   task automatic wait_start(input int bound);
      seen = 1'b0;
      for (int n = 0; n < bound && !seen; n++) begin
         @(negedge clk);
         seen = ctrl.conversion_start === 1'b1;
      end
   endtask : wait_start

   task automatic wait_res(input int want);
      int n;
      for (n = 0; n < 200 && n_res < want; n++) @(posedge clk);
      if (n_res < want) timed_out();
   endtask : wait_res

   initial begin
      rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
      pin = 1'b0; pwm = 1'b0; delay = 8'h03; chan = 3'h0; data = 12'h000;
      n_res = 0; checked = 0; bad_count = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
      // reserved bits stay zero, byte lanes act alone, unmapped places refused
      wr(ADDR_CTRL, 32'h7fff_f000, 4'hf, RESP_OKAY);
      rd(ADDR_CTRL, 32'h0, RESP_OKAY);
      wr(ADDR_CTRL, 32'h8000_07fe, 4'hf, RESP_OKAY);
      check(ctrl, 32'h8000_07fe);
      wr(ADDR_CTRL, 32'h0, 4'h2, RESP_OKAY);
      rd(ADDR_CTRL, 32'h8000_00fe, RESP_OKAY);
      wr(ADDR_CTRL, 32'h0, 4'h8, RESP_OKAY);
      wr(8'h24, 32'hffff_ffff, 4'hf, RESP_SLVERR);
      rd(ADDR_CTRL, 32'h0000_00fe, RESP_OKAY);
      rd(8'h24, 32'h0, RESP_SLVERR);
      wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
      // formats, pairing and dma requests; dma cases keep irq enable low
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         chan <= ch_tab[i]; data <= d_tab[i]; delay <= (i % 2 == 1) ? 8'd20 : 8'd3;
         n0 = n_res;
         wr(ADDR_CTRL, ctl_tab[i], 4'hf, RESP_OKAY);
         wait_res(n0 + 1);
         check({10'h0, res_seen}, {10'h0, exp_tab[i]});
         check({31'h0, dma_seen}, {31'h0, ctl_tab[i][9]});
         repeat (2) @(posedge clk);
         rd(ADDR_CTRL, ctl_tab[i] & 32'hffff_f7ff, RESP_OKAY);
      end
      // continuous scan keeps going until software clears start
      n0 = n_res;
      wr(ADDR_CTRL, 32'h0000_080d, 4'hf, RESP_OKAY);
      wait_res(n0 + 3);
      rd(ADDR_CTRL, 32'h0000_080d, RESP_OKAY);
      wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
      repeat (3) @(posedge clk);
      n0 = n_res;
      repeat (40) @(posedge clk);
      check(n_res - n0, 32'h0);
      // pwm trigger honoured only when enabled, in single-cycle scan, from source 11
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_CTRL, hw_tab[i], 4'hf, RESP_OKAY);
         @(posedge clk);
         pwm <= 1'b1;
         @(posedge clk);
         pwm <= 1'b0;
         wait_start(10);
         check({31'h0, seen}, {31'h0, i == 0});
         wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
      end
      // external pin, each condition from its idle level
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         pin <= (c == 0 || c == 2);
         repeat (20) @(posedge clk);
         wr(ADDR_CTRL, 32'h109 | (c << 6), 4'hf, RESP_OKAY);
         repeat (20) @(posedge clk);
         rd(ADDR_CTRL, 32'h109 | (c << 6), RESP_OKAY);
         @(posedge clk);
         pin <= !(c == 0 || c == 2);
         wait_start(30);
         check({31'h0, seen}, 32'h1);
         @(posedge clk);
         pin <= (c == 0 || c == 2);
         repeat (20) @(posedge clk);
         wr(ADDR_CTRL, 32'h0, 4'hf, RESP_OKAY);
      end
      stop_test();
   end
endmodule : acc_conversion_control_tb
